// ===== hw/sac_ctrl.sv
// Conversion control of the successive-approximation converter with AXI4-Lite registers
`timescale 1ns/1ps
module sac_ctrl (
    input  wire logic        i_clk_sys,       // Bus clock, 10 MHz
    input  wire logic        i_reset_n,       // Async reset, active low
    input  wire logic [7:0]  i_awaddr,        // Write address
    input  wire logic        i_awvalid,       // Write address valid
    output logic             o_awready,       // Write address ready
    input  wire logic [31:0] i_wdata,         // Write data
    input  wire logic [3:0]  i_wstrb,         // Write strobes
    input  wire logic        i_wvalid,        // Write data valid
    output logic             o_wready,        // Write data ready
    output logic [1:0]       o_bresp,         // Write response
    output logic             o_bvalid,        // Write response valid
    input  wire logic        i_bready,        // Write response ready
    input  wire logic [7:0]  i_araddr,        // Read address
    input  wire logic        i_arvalid,       // Read address valid
    output logic             o_arready,       // Read address ready
    output logic [31:0]      o_rdata,         // Read data
    output logic [1:0]       o_rresp,         // Read response
    output logic             o_rvalid,        // Read data valid
    input  wire logic        i_rready,        // Read data ready
    input  wire logic        i_alt_clk,       // Alternate clock pin
    input  wire logic        i_async_clk,     // Internal async oscillator output
    input  wire logic        i_hw_trigger,    // Hardware trigger input
    input  wire logic [11:0] i_sar_value,     // Analog core approximation value
    input  wire logic [7:0]  i_pin_in,        // Raw input of pins 16..23
    input  wire logic [7:0]  i_port_out,      // Port output data of pins 16..23
    input  wire logic [7:0]  i_port_oe,       // Port output enable of pins 16..23
    input  wire logic [7:0]  i_port_pull,     // Port pull-up enable of pins 16..23
    output logic [7:0]       o_pin_out,       // Pin output data
    output logic [7:0]       o_pin_oe,        // Pin output enable
    output logic [7:0]       o_pin_pull_en,   // Pin pull-up enable
    output logic [7:0]       o_pin_ibuf_en,   // Pin input buffer enable
    output logic [4:0]       o_channel,       // Channel to the analog mux
    output logic             o_conv_clk,      // Conversion clock tick
    output logic             o_async_clk_en,  // Internal async clock generator on
    output logic             o_analog_en,     // Analog core powered
    output logic             o_irq            // Completion interrupt
);
    import sac_pkg::*;

    function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
        return s[0] ? d[7:0] : old;
    endfunction

    // Sync of external inputs
    logic [3:0] sync1_q, sync2_q, sync1_d, sync2_d;
    logic [7:0] pin1_q, pin2_q;
    logic       trig_prev_q, div_src_prev_q;
    logic       half_q, half_d;
    logic [2:0] div_cnt_q, div_cnt_d;
    logic       tick_q, tick_d;

    assign sync1_d = {1'b0, i_hw_trigger, i_alt_clk, i_async_clk};
    assign sync2_d = sync1_q;

    // Registers
    logic [7:0]  sc1_q, sc1_d, sc2_q, sc2_d, cfg_q, cfg_d, pin_q, pin_d;
    logic [7:0]  cvh_q, cvh_d, cvl_q, cvl_d, rh_q, rh_d, rl_q, rl_d;
    logic        conversion_complete_flag_q, conversion_complete_flag_d, hi_read_q, hi_read_d;
    sac_state_t  st_q, st_d;
    logic [3:0]  step_q, step_d;
    logic        launched_q, launched_d;
    // Bus state
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;

    logic        clk_src, trig_rise, wr_go, rd_go, start, abort, done, mapped_w;
    logic [12:0] rounded;
    logic [12:0] diff;
    logic        cmp_true, block, sc1_wr, ch_off;
    logic [1:0]  mode;
    logic [4:0]  ch;

    assign mode   = cfg_q[CFG_MODE_L+1:CFG_MODE_L];
    assign ch     = sc1_q[SC1_CH_H:0];
    assign ch_off = (ch == CH_OFF);

    // Input clock select then divide
    always_comb begin
        unique case (cfg_q[CFG_CLK_L+1:CFG_CLK_L])
            CLK_BUS:      clk_src = 1'b1;
            CLK_BUS_HALF: clk_src = half_q;
            CLK_ALT:      clk_src = sync2_q[1] & ~div_src_prev_q;
            default:      clk_src = sync2_q[0] & ~div_src_prev_q;
        endcase
        half_d = ~half_q;
        div_cnt_d = div_cnt_q;
        tick_d = 1'b0;
        if (clk_src) begin
            div_cnt_d = div_cnt_q + 3'h1;
            unique case (cfg_q[CFG_DIV_L+1:CFG_DIV_L])
                2'h0:    tick_d = 1'b1;
                2'h1:    tick_d = div_cnt_q[0];
                2'h2:    tick_d = &div_cnt_q[1:0];
                default: tick_d = &div_cnt_q;
            endcase
        end
    end

    // Write and read sides of the bus
    assign wr_go  = aw_q & w_q & ~bv_q;
    assign rd_go  = i_arvalid & ~rv_q;
    assign sc1_wr = wr_go & (awa_q == ADDR_SC1) & ws_q[0];
    assign mapped_w = (awa_q <= ADDR_PIN_UP);

    always_comb begin
        aw_d = aw_q;
        w_d  = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_d = rd_q;
        if (i_awvalid && !aw_q) begin
            aw_d = 1'b1;
            awa_d = i_awaddr;
        end
        if (i_wvalid && !w_q) begin
            w_d = 1'b1;
            wd_d = i_wdata;
            ws_d = i_wstrb;
        end
        if (wr_go) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = mapped_w ? AXI_OKAY : AXI_SLVERR;
        end
        if (bv_q && i_bready) bv_d = 1'b0;
        if (rd_go) begin
            rv_d = 1'b1;
            rr_d = AXI_OKAY;
            unique case (i_araddr)
                ADDR_SC1:     rd_d = {24'h0, conversion_complete_flag_q, sc1_q[6:0]};
                ADDR_SC2:     rd_d = {24'h0, st_q == SAC_CONV, sc2_q[6:0]};
                ADDR_RES_HI:  rd_d = {24'h0, rh_q};
                ADDR_RES_LO:  rd_d = {24'h0, rl_q};
                ADDR_CMP_HI:  rd_d = {24'h0, cvh_q};
                ADDR_CMP_LO:  rd_d = {24'h0, cvl_q};
                ADDR_CFG:     rd_d = {24'h0, cfg_q};
                ADDR_PIN_UP:  rd_d = {24'h0, pin_q};
                ADDR_PORT_IN: rd_d = {24'h0, pin2_q & ~pin_q};
                default: begin
                    rd_d = 32'h0;
                    rr_d = AXI_SLVERR;
                end
            endcase
        end else if (rv_q && i_rready) begin
            rv_d = 1'b0;
        end
    end

    // Rounding and compare
    always_comb begin
        unique case (mode)
            MODE_8:  rounded = 13'((10'(i_sar_value[11:3]) + 10'h1) >> 1);
            MODE_10: rounded = 13'((12'(i_sar_value[11:1]) + 12'h1) >> 1);
            default: rounded = {1'b0, i_sar_value};
        endcase
        if (rounded[12] || (mode == MODE_8 && rounded[8]) || (mode == MODE_10 && rounded[10]))
            rounded = (mode == MODE_8) ? 13'h0ff : (mode == MODE_10) ? 13'h3ff : 13'hfff;
        diff = rounded - {1'b0, (mode == MODE_8) ? 4'h0 : cvh_q[3:0], cvl_q};
        cmp_true = sc2_q[SC2_ACGT] ? ~diff[12] : diff[12];
    end

    assign block = (mode != MODE_8) && hi_read_q;
    // Last of the SAMPLE_TICKS + 12 ticks, counted from zero
    assign done  = (st_q == SAC_CONV) && tick_q && (step_q == 4'(SAMPLE_TICKS + 11));
    assign abort = wr_go && mapped_w && ws_q[0] &&
                   (awa_q <= ADDR_CMP_LO || awa_q == ADDR_CFG) &&
                   awa_q != ADDR_RES_HI && awa_q != ADDR_RES_LO;

    // Conversion sequencing
    always_comb begin
        st_d = st_q;
        step_d = step_q;
        launched_d = launched_q;
        start = 1'b0;
        conversion_complete_flag_d = conversion_complete_flag_q;
        rh_d = rh_q;
        rl_d = rl_q;
        hi_read_d = hi_read_q;
        sc1_d = sc1_q;
        sc2_d = sc2_q;
        cfg_d = cfg_q;
        pin_d = pin_q;
        cvh_d = cvh_q;
        cvl_d = cvl_q;
        if (rd_go && i_araddr == ADDR_RES_HI) hi_read_d = 1'b1;
        if (rd_go && i_araddr == ADDR_RES_LO) hi_read_d = 1'b0;
        if (rd_go && (i_araddr == ADDR_RES_HI || i_araddr == ADDR_RES_LO)) conversion_complete_flag_d = 1'b0;
        if (wr_go && ws_q[0]) begin
            unique case (awa_q)
                ADDR_SC1:    sc1_d = {1'b0, wd_q[6:0]};
                ADDR_SC2:    sc2_d = {1'b0, wd_q[6:4], 4'h0};
                ADDR_CMP_HI: cvh_d = {4'h0, wd_q[3:0]};
                ADDR_CMP_LO: cvl_d = lane(cvl_q, wd_q, ws_q);
                ADDR_CFG:    cfg_d = wd_q[7:0];
                ADDR_PIN_UP: pin_d = wd_q[7:0];
                default:     ;
            endcase
        end
        if (sc1_wr) conversion_complete_flag_d = 1'b0;
        if (trig_rise && sc2_q[SC2_HWT] && st_q == SAC_IDLE &&
            !(sc1_q[SC1_ACO] && launched_q))
            start = 1'b1;
        if (sc1_wr && !sc2_q[SC2_HWT] && wd_q[SC1_CH_H:0] != CH_OFF)
            start = 1'b1;
        if (st_q == SAC_CONV && tick_q) step_d = step_q + 4'h1;
        if (done) begin
            if (sc2_q[SC2_COMPARE_ENABLE] && !cmp_true) begin
                st_d = sc1_q[SC1_ACO] ? SAC_CONV : SAC_IDLE;
                step_d = 4'h0;
            end else if (block) begin
                step_d = 4'h0;
            end else begin
                rh_d = {3'h0, rounded[12:8]} & {8{mode != MODE_8}};
                rl_d = rounded[7:0];
                conversion_complete_flag_d = 1'b1;
                st_d = sc1_q[SC1_ACO] ? SAC_CONV : SAC_IDLE;
                step_d = 4'h0;
            end
        end
        // Abort never wakes a disabled converter
        if (start || (abort && st_q != SAC_OFF)) begin
            st_d = start ? SAC_CONV : SAC_IDLE;
            step_d = 4'h0;
            launched_d = start;
        end
        if (sc1_wr && wd_q[SC1_CH_H:0] == CH_OFF) begin
            st_d = SAC_OFF;
            launched_d = 1'b0;
        end else if (st_q == SAC_OFF && !ch_off) begin
            st_d = SAC_IDLE;
        end
        if (!sc1_q[SC1_ACO] && !sc2_q[SC2_HWT]) launched_d = (st_d == SAC_CONV);
    end

    assign trig_rise = sync2_q[2] & ~trig_prev_q;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            pin1_q <= 8'h0;
            pin2_q <= 8'h0;
            trig_prev_q <= 1'b0;
            div_src_prev_q <= 1'b0;
            half_q <= 1'b0;
            div_cnt_q <= 3'h0;
            tick_q <= 1'b0;
            sc1_q <= SC1_RESET;
            sc2_q <= 8'h0;
            cfg_q <= CFG_RESET;
            pin_q <= PIN_RESET;
            cvh_q <= 8'h0;
            cvl_q <= 8'h0;
            rh_q <= 8'h0;
            rl_q <= 8'h0;
            conversion_complete_flag_q <= 1'b0;
            hi_read_q <= 1'b0;
            st_q <= SAC_OFF;
            step_q <= 4'h0;
            launched_q <= 1'b0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h0;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            bv_q <= 1'b0;
            br_q <= AXI_OKAY;
            rv_q <= 1'b0;
            rr_q <= AXI_OKAY;
            rd_q <= 32'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            pin1_q <= i_pin_in;
            pin2_q <= pin1_q;
            trig_prev_q <= sync2_q[2];
            div_src_prev_q <= (cfg_q[1:0] == CLK_ALT) ? sync2_q[1] : sync2_q[0];
            half_q <= half_d;
            div_cnt_q <= div_cnt_d;
            tick_q <= tick_d;
            sc1_q <= sc1_d;
            sc2_q <= sc2_d;
            cfg_q <= cfg_d;
            pin_q <= pin_d;
            cvh_q <= cvh_d;
            cvl_q <= cvl_d;
            rh_q <= rh_d;
            rl_q <= rl_d;
            conversion_complete_flag_q <= conversion_complete_flag_d;
            hi_read_q <= hi_read_d;
            st_q <= st_d;
            step_q <= step_d;
            launched_q <= launched_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rr_q <= rr_d;
            rd_q <= rd_d;
        end
    end

    assign o_awready = ~aw_q;
    assign o_wready  = ~w_q;
    assign o_bvalid  = bv_q;
    assign o_bresp   = br_q;
    assign o_arready = ~rv_q;
    assign o_rvalid  = rv_q;
    assign o_rdata   = rd_q;
    assign o_rresp   = rr_q;
    assign o_pin_out     = i_port_out & ~pin_q;
    assign o_pin_oe      = i_port_oe & ~pin_q;
    assign o_pin_pull_en = i_port_pull & ~pin_q;
    assign o_pin_ibuf_en = ~pin_q;
    assign o_channel     = ch;
    assign o_conv_clk    = tick_q;
    assign o_async_clk_en = (cfg_q[1:0] == CLK_ASYNC) && (st_q == SAC_CONV);
    assign o_analog_en   = (st_q == SAC_CONV);
    assign o_irq         = conversion_complete_flag_q & sc1_q[SC1_COMPLETE_IRQ_ENABLE];
endmodule

// ===== hw/sac_pkg.sv
// Package: register map, field layout and constants for the conversion control
// Behaviour
// - Upper pin-disable register: bits 7..0 serve channels 23..16, set removes port control.
// - Disabled pin: input buffer off, port read returns zero.
// - Disabled pin: output driver high impedance, pull-up off.
// - Converter disabled during reset and while channel select is all ones.
// - After completion and until next start, converter sits idle at lowest power.
// - 8-bit mode yields 9-bit internal value; 10-bit yields 11 bits, 12-bit yields 12 bits.
// - 10-bit mode rounds to ten bits into high and low result registers.
// - 8-bit mode rounds to eight bits, written to low result only.
// - Completion transfers result, sets complete flag, interrupts when enable high.
// - Compare enable compares every result against compare registers in all modes.
// - Two-bit clock select picks one of four clocks; reset selects bus clock.
// - Selected clock divided by 1, 2, 4 or 8 forms conversion clock.
// - Internal async clock generated inside, keeps running in wait and stop3.
// - With hardware trigger enabled, each trigger rising edge starts a conversion.
// - Trigger edge during a conversion is discarded.
// - Hardware trigger plus continuous: only first edge launches, later ignored.
// - Software mode: status/control one write with channel not all ones starts.
// - Continuous mode restarts after each transfer until aborted.
// - 12/10-bit: high read, low unread blocks transfer; flag clear; result lost.
// - Single conversion, compare on and false: blocking moot, converter stops.
// - Any other blocked transfer starts another conversion, single or continuous.
// - Clock select: 00 bus, 01 bus half, 10 alternate, 11 internal async.
// - Resolution: 00 8-bit, 01 12-bit, 10 10-bit, 11 reserved.
package sac_pkg;
    localparam logic [7:0] ADDR_SC1      = 8'h00;
    localparam logic [7:0] ADDR_SC2      = 8'h04;
    localparam logic [7:0] ADDR_RES_HI   = 8'h08;
    localparam logic [7:0] ADDR_RES_LO   = 8'h0c;
    localparam logic [7:0] ADDR_CMP_HI   = 8'h10;
    localparam logic [7:0] ADDR_CMP_LO   = 8'h14;
    localparam logic [7:0] ADDR_CFG      = 8'h18;
    localparam logic [7:0] ADDR_PIN_UP   = 8'h1c;
    localparam logic [7:0] ADDR_PORT_IN  = 8'h20;
    // Status/control one fields
    localparam int SC1_CONVERSION_COMPLETE_FLAG = 7;
    localparam int SC1_COMPLETE_IRQ_ENABLE = 6;
    localparam int SC1_ACO  = 5;
    localparam int SC1_CH_H = 4;
    // Status/control two fields
    localparam int SC2_ACT  = 7;
    localparam int SC2_HWT  = 6;
    localparam int SC2_COMPARE_ENABLE = 5;
    localparam int SC2_ACGT = 4;
    // Configuration fields
    localparam int CFG_DIV_L  = 5;
    localparam int CFG_MODE_L = 2;
    localparam int CFG_CLK_L  = 0;
    localparam logic [4:0] CH_OFF    = 5'h1f;
    localparam logic [7:0] SC1_RESET = 8'h1f;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] PIN_RESET = 8'h00;
    localparam logic [1:0] MODE_8  = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [1:0] CLK_BUS      = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF = 2'h1;
    localparam logic [1:0] CLK_ALT      = 2'h2;
    localparam logic [1:0] CLK_ASYNC    = 2'h3;
    // Sample phase length in conversion clock periods
    localparam int SAMPLE_TICKS = 4;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        SAC_OFF  = 3'b001,
        SAC_IDLE = 3'b010,
        SAC_CONV = 3'b100
    } sac_state_t;
endpackage

// ===== tb/sac_ctrl_asserts.sv
// Port checker for the conversion control block
`timescale 1ns/1ps
module sac_ctrl_asserts (
    input wire logic        i_clk_sys,      // Clock
    input wire logic        i_reset_n,      // Reset
    input wire logic [7:0]  i_port_out,     // Port data
    input wire logic [7:0]  i_port_oe,      // Port enable
    input wire logic [7:0]  i_port_pull,    // Port pull
    input wire logic [7:0]  o_pin_out,      // Pin data
    input wire logic [7:0]  o_pin_oe,       // Pin enable
    input wire logic [7:0]  o_pin_pull_en,  // Pin pull
    input wire logic [7:0]  o_pin_ibuf_en,  // Input buffer
    input wire logic [4:0]  o_channel,      // Channel
    input wire logic        o_analog_en,    // Converting
    input wire logic        o_async_clk_en, // Async clock on
    input wire logic        o_bvalid,       // Write resp valid
    input wire logic [1:0]  o_bresp,        // Write resp
    input wire logic        i_bready,       // Write resp ready
    input wire logic        o_rvalid,       // Read valid
    input wire logic [31:0] o_rdata,        // Read data
    input wire logic        i_rready,       // Read ready
    input wire logic        o_arready       // Read addr ready
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    chk_pin_out_mask: assert property (o_pin_out == (i_port_out & o_pin_ibuf_en))
        else $error("pin data not masked");
    chk_pin_oe_mask: assert property (o_pin_oe == (i_port_oe & o_pin_ibuf_en))
        else $error("pin enable not masked");
    chk_pull_mask: assert property (o_pin_pull_en == (i_port_pull & o_pin_ibuf_en))
        else $error("pull not masked");
    chk_off_no_power: assert property (o_channel == 5'h1f [*3] |-> !o_analog_en)
        else $error("converter on with channel off");
    chk_async_only_busy: assert property (o_async_clk_en |-> o_analog_en)
        else $error("async clock on while idle");
    chk_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    chk_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    chk_ar_refused: assert property (o_rvalid |-> !o_arready)
        else $error("read address taken while busy");
endmodule

bind sac_ctrl sac_ctrl_asserts u_asserts (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_port_out(i_port_out),
    .i_port_oe(i_port_oe), .i_port_pull(i_port_pull), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_pin_pull_en(o_pin_pull_en), .o_pin_ibuf_en(o_pin_ibuf_en),
    .o_channel(o_channel), .o_analog_en(o_analog_en), .o_async_clk_en(o_async_clk_en),
    .o_bvalid(o_bvalid), .o_bresp(o_bresp), .i_bready(i_bready), .o_rvalid(o_rvalid),
    .o_rdata(o_rdata), .i_rready(i_rready), .o_arready(o_arready)
);

// ===== tb/test_sac_ctrl.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
module test_sac_ctrl;
    import sac_pkg::*;
    logic        i_clk_sys = 1'b0, i_reset_n = 1'b0;
    logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0]  i_wstrb = 4'h1;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0;
    logic        i_alt_clk = 1'b0, i_async_clk = 1'b0, i_hw_trigger = 1'b0;
    logic [11:0] i_sar_value = 12'h000;
    logic [7:0]  i_pin_in = 8'h00, i_port_out = 8'h00, i_port_oe = 8'h00, i_port_pull = 8'h00;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]  o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [7:0]  o_pin_out, o_pin_oe, o_pin_pull_en, o_pin_ibuf_en;
    logic [4:0]  o_channel;
    logic        o_conv_clk, o_async_clk_en, o_analog_en, o_irq;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          c;
    logic [31:0] rv;
    logic [1:0]  rsp;

    sac_ctrl DUT (.i_clk_sys, .i_reset_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
        .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_alt_clk,
        .i_async_clk, .i_hw_trigger, .i_sar_value, .i_pin_in, .i_port_out, .i_port_oe,
        .i_port_pull, .o_pin_out, .o_pin_oe, .o_pin_pull_en, .o_pin_ibuf_en, .o_channel,
        .o_conv_clk, .o_async_clk_en, .o_analog_en, .o_irq);

    initial forever #50 i_clk_sys = ~i_clk_sys;
    initial begin
        #37;
        forever #300 i_alt_clk = ~i_alt_clk;
    end
    initial begin
        #11;
        forever #400 i_async_clk = ~i_async_clk;
    end

    task wrap_up;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task timeout;
        error_cnt++;
        $display("[ERR] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = AXI_OKAY);
        int n;
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_clk_sys);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (o_bvalid && i_bready) break;
            if (o_bvalid) i_bready <= 1'b1;
        end
        if (n == 100) timeout();
        i_bready <= 1'b0;
        chk(o_bresp, er);
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = AXI_OKAY);
        int n;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge i_clk_sys);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (o_rvalid && i_rready) break;
            if (o_rvalid) i_rready <= 1'b1;
        end
        if (n == 100) timeout();
        i_rready <= 1'b0;
        chk(o_rresp, er);
        chk(o_rdata, {24'h0, e});
    endtask

    task wait_en(input logic lvl);
        for (int n = 0; n < 400; n++) begin
            @(posedge i_clk_sys);
            if (o_analog_en === lvl) return;
        end
        timeout();
    endtask

    task busy_cnt(input int n);
        c = 0;
        repeat (n) begin
            @(posedge i_clk_sys);
            if (o_analog_en === 1'b1) c++;
        end
    endtask

    task tick_gap(output int g);
        int n;
        n = 0;
        g = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_conv_clk !== 1'b1 && n < 300);
        do begin
            @(posedge i_clk_sys);
            g++;
        end while (o_conv_clk !== 1'b1 && g < 300);
        if (n == 300 || g == 300) timeout();
    endtask

    task t_reset;
        rdc(ADDR_SC1, 8'h1f);
        rdc(ADDR_CFG, 8'h00);
        rdc(ADDR_PIN_UP, 8'h00);
        chk(o_analog_en, 1'b0);
        chk(o_pin_ibuf_en, 8'hff);
        $display("test reset done");
    endtask

    task t_pins;
        i_pin_in <= 8'hff;
        i_port_out <= 8'hff;
        i_port_oe <= 8'hff;
        i_port_pull <= 8'hff;
        wr(ADDR_PIN_UP, 8'ha5);
        rdc(ADDR_PIN_UP, 8'ha5);
        i_wstrb <= 4'h0;
        wr(ADDR_PIN_UP, 8'h00);
        i_wstrb <= 4'h1;
        rdc(ADDR_PIN_UP, 8'ha5);
        chk(o_pin_out, 8'h5a);
        repeat (3) @(posedge i_clk_sys);
        rdc(ADDR_PORT_IN, 8'h5a);
        chk(o_pin_ibuf_en, 8'h5a);
        chk(o_pin_oe, 8'h5a);
        chk(o_pin_pull_en, 8'h5a);
        wr(8'h24, 8'h00, AXI_SLVERR);
        rdc(8'h24, 8'h00, AXI_SLVERR);
        $display("test pins done");
    endtask

    task t_clocks;
        logic [7:0] cfg_t [7] = '{8'h04, 8'h24, 8'h44, 8'h64, 8'h05, 8'h06, 8'h27};
        int         gap_t [7] = '{1, 2, 4, 8, 2, 6, 16};
        int         g;
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_CFG, cfg_t[i]);
            wr(ADDR_SC1, 8'h03);
            tick_gap(g);
            chk(g, gap_t[i]);
            chk(o_async_clk_en, i == 6);
            wr(ADDR_SC1, CH_OFF);
            repeat (3) @(posedge i_clk_sys);
            chk(o_analog_en, 1'b0);
        end
        $display("test clocks done");
    endtask

    task t_modes;
        logic [15:0] exp_t [4] = '{16'h00ab, 16'h0ab7, 16'h02ae, 16'h0ab7};
        i_sar_value <= 12'hab7;
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CFG, 8'(m * 4));
            wr(ADDR_SC1, 8'h43);
            wait_en(1'b1);
            wait_en(1'b0);
            chk(o_irq, 1'b1);
            rdc(ADDR_SC1, 8'hc3);
            chk(o_analog_en, 1'b0);
            rdc(ADDR_RES_HI, exp_t[m][15:8]);
            rdc(ADDR_RES_LO, exp_t[m][7:0]);
            chk(o_irq, 1'b0);
        end
        $display("test modes done");
    endtask

    task t_hwtrig;
        wr(ADDR_CFG, 8'h04);
        wr(ADDR_SC2, 8'h40);
        wr(ADDR_SC1, 8'h03);
        repeat (5) @(posedge i_clk_sys);
        chk(o_analog_en, 1'b0);
        i_hw_trigger <= 1'b1;
        wait_en(1'b1);
        i_hw_trigger <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_hw_trigger <= 1'b1;
        wait_en(1'b0);
        repeat (6) @(posedge i_clk_sys);
        chk(o_analog_en, 1'b0);
        i_hw_trigger <= 1'b0;
        wr(ADDR_SC1, 8'h23);
        i_hw_trigger <= 1'b1;
        busy_cnt(60);
        chk(c > 50, 1'b1);
        wr(ADDR_SC1, CH_OFF);
        repeat (3) @(posedge i_clk_sys);
        chk(o_analog_en, 1'b0);
        i_hw_trigger <= 1'b0;
        wr(ADDR_SC2, 8'h00);
        $display("test trigger done");
    endtask

    task t_block;
        wr(ADDR_SC1, 8'h03);
        wait_en(1'b1);
        wait_en(1'b0);
        rdc(ADDR_RES_HI, 8'h0a);
        i_sar_value <= 12'h5c3;
        wr(ADDR_SC1, 8'h03);
        busy_cnt(45);
        chk(c > 35, 1'b1);
        rdc(ADDR_SC1, 8'h03);
        rdc(ADDR_RES_LO, 8'hb7);
        repeat (40) @(posedge i_clk_sys);
        chk(o_analog_en, 1'b0);
        rdc(ADDR_SC1, 8'h83);
        rdc(ADDR_RES_HI, 8'h05);
        rdc(ADDR_RES_LO, 8'hc3);
        $display("test blocking done");
    endtask

    task t_compare;
        wr(ADDR_CMP_HI, 8'h01);
        wr(ADDR_CMP_LO, 8'h00);
        wr(ADDR_SC2, 8'h20);
        i_sar_value <= 12'hab7;
        rdc(ADDR_RES_HI, 8'h05);
        wr(ADDR_SC1, 8'h03);
        wait_en(1'b1);
        busy_cnt(40);
        chk(o_analog_en, 1'b0);
        rdc(ADDR_SC1, 8'h03);
        rdc(ADDR_RES_LO, 8'hc3);
        i_sar_value <= 12'h050;
        wr(ADDR_SC1, 8'h03);
        wait_en(1'b1);
        wait_en(1'b0);
        rdc(ADDR_SC1, 8'h83);
        rdc(ADDR_RES_HI, 8'h00);
        rdc(ADDR_RES_LO, 8'h50);
        wr(ADDR_SC2, 8'h00);
        $display("test compare done");
    endtask

    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        @(posedge i_clk_sys);
        t_reset();
        t_pins();
        t_clocks();
        t_modes();
        t_hwtrig();
        t_block();
        t_compare();
        wrap_up();
    end
endmodule
